//--- design/chan_event_detect.sv
/*
  Event detector of one timer channel: overflow, capture and compare events
  turned into one-cycle set requests {overflow, D, C, B, A}.
  Assumes counter and general registers are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_status_defines.svh"

module chan_event_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Channel signals
  chan_events_if.detector ch
);
  import timer_status_pkg::*;

  typedef struct packed {
    word16_t prev_count;
    logic primed;
  } det_state_t;

  det_state_t s_q;
  det_state_t s_d;
  reg_bits_t hit;
  logic changed;

  always_comb begin
    s_d = s_q;
    s_d.prev_count = ch.count;
    s_d.primed = 1'b1;
    // Compare only when the count moves, so a stalled counter does not re-set a cleared flag
    changed = s_q.primed && (ch.count != s_q.prev_count);
    for (int i = 0; i < 4; i++) begin
      hit[i] = (ch.capture_strobe[i] && ch.capture_mode[i]) ||
               (changed && !ch.capture_mode[i] && (ch.count == ch.general[i]));
    end
    ch.set_flags[4] = s_q.primed && (s_q.prev_count == `TS_COUNT_MAX) &&
                      (ch.count == `TS_COUNT_MIN);
    ch.set_flags[3] = hit[3];
    ch.set_flags[2] = hit[2] && !ch.pwm_mode;
    ch.set_flags[1] = hit[1] && !ch.pwm_mode;
    ch.set_flags[0] = hit[0] && !ch.pwm_mode;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

`default_nettype wire

//--- design/chan_events_if.sv
/*
  Signals of one timer channel as seen by its event detector.
  Assumes the top module drives the channel side and reads set_flags.
*/
`timescale 1ns/1ps
`default_nettype none

interface chan_events_if;
  import timer_status_pkg::*;
  word16_t count;
  logic [3:0][15:0] general;
  reg_bits_t capture_strobe;
  reg_bits_t capture_mode;
  logic pwm_mode;
  chan_set_t set_flags;
  modport source (output count, output general, output capture_strobe, output capture_mode,
                  output pwm_mode, input set_flags);
  modport detector (input count, input general, input capture_strobe, input capture_mode,
                    input pwm_mode, output set_flags);
endinterface

`default_nettype wire

//--- design/timer_status_defines.svh
/*
  Offsets, field positions, reset values and masks of the status flag
  block for timer channels 3 to 5.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef TIMER_STATUS_DEFINES_SVH
`define TIMER_STATUS_DEFINES_SVH

// Byte offsets on the register bus
`define TS_OFS_STATUS 4'h0
`define TS_OFS_ENABLE 4'h4
`define TS_OFS_CLEAR 4'h8

// Flag layout: channel n occupies a five-bit slice, A to D then overflow
`define TS_CHANNELS 3
`define TS_CH_STRIDE 5
`define TS_BIT_OVF_FIVE 14
`define TS_BIT_FLAG_D_FIVE 13
`define TS_BIT_FLAG_C_FIVE 12
`define TS_BIT_FLAG_B_FIVE 11
`define TS_BIT_FLAG_A_FIVE 10
`define TS_BIT_OVF_FOUR 9
`define TS_BIT_OVF_THREE 4
`define TS_BIT_RESERVED 15

// Reset values, masks and counter wrap limits
`define TS_FLAGS_RESET 16'h0000
`define TS_ENABLE_RESET 16'h0000
`define TS_FLAG_MASK 16'h7fff
`define TS_COUNT_MAX 16'hffff
`define TS_COUNT_MIN 16'h0000

`endif

//--- design/timer_status_pkg.sv
/*
  Types shared by the status flag block for timer channels 3 to 5.
  Assumes the constants header is on the include path.
*/
`include "timer_status_defines.svh"

package timer_status_pkg;
  typedef logic [15:0] word16_t;
  typedef logic [3:0] reg_bits_t;
  typedef logic [4:0] chan_set_t;
  typedef logic [`TS_CHANNELS-1:0][15:0] chan_count_t;
  typedef logic [`TS_CHANNELS-1:0][3:0][15:0] chan_general_t;
  typedef logic [`TS_CHANNELS-1:0][3:0] chan_reg_bits_t;
  typedef logic [`TS_CHANNELS-1:0] chan_bit_t;
  typedef logic [3:0] wb_addr_t;
  typedef logic [31:0] wb_data_t;
  typedef logic [3:0] wb_sel_t;
endpackage

//--- design/timer_status_regs.sv
/*
  Status flag register for timer channels 3 to 5 with interrupt gating,
  reached over a classic Wishbone slave.
  Assumes counters, general registers and capture strobes are synchronous to clk.
*/
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "timer_status_defines.svh"

module timer_status_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire timer_status_pkg::wb_addr_t wb_adr_i,
  input wire timer_status_pkg::wb_sel_t wb_sel_i,
  input wire timer_status_pkg::wb_data_t wb_dat_i,
  output logic wb_ack_o,
  output timer_status_pkg::wb_data_t wb_dat_o,
  // Channels 3 to 5, index 0 is channel 3
  input wire timer_status_pkg::chan_count_t chan_count,
  input wire timer_status_pkg::chan_general_t chan_general,
  input wire timer_status_pkg::chan_reg_bits_t chan_capture_strobe,
  input wire timer_status_pkg::chan_reg_bits_t chan_capture_mode,
  input wire timer_status_pkg::chan_bit_t chan_pwm_mode,
  // Interrupt
  output logic irq
);
  import timer_status_pkg::*;

  typedef struct packed {
    word16_t flags;
    word16_t armed;
    word16_t enable;
    logic ack;
    wb_data_t dat;
    logic irq;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;
  word16_t set_all;
  word16_t lane_mask;
  word16_t clr;
  logic access;
  logic wr_status;
  logic wr_clear;

  genvar g;
  generate
    for (g = 0; g < `TS_CHANNELS; g++) begin : g_chan
      chan_events_if chif ();
      assign chif.count = chan_count[g];
      assign chif.general = chan_general[g];
      assign chif.capture_strobe = chan_capture_strobe[g];
      assign chif.capture_mode = chan_capture_mode[g];
      assign chif.pwm_mode = chan_pwm_mode[g];
      chan_event_detect u_det (
        .clk(clk),
        .sys_rst(sys_rst),
        .ch(chif.detector)
      );
      assign set_all[g*`TS_CH_STRIDE +: `TS_CH_STRIDE] = chif.set_flags;
    end
  endgenerate
  assign set_all[`TS_BIT_RESERVED] = 1'b0;

  always_comb begin
    s_d = s_q;
    // One request at a time; ack drops the cycle after it was given
    access = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.ack = access;
    lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wr_status = access && wb_we_i && (wb_adr_i == `TS_OFS_STATUS);
    wr_clear = access && wb_we_i && (wb_adr_i == `TS_OFS_CLEAR);
    clr = '0;
    if (access && !wb_we_i) begin
      unique case (wb_adr_i)
        `TS_OFS_STATUS: begin
          s_d.dat = {16'h0000, s_q.flags & `TS_FLAG_MASK};
          s_d.armed = s_q.armed | s_q.flags;
        end
        `TS_OFS_ENABLE: begin
          s_d.dat = {16'h0000, s_q.enable};
        end
        default: begin
          s_d.dat = '0;
        end
      endcase
    end
    // Zero clears an armed flag, one leaves it
    if (wr_status) begin
      clr = lane_mask & ~wb_dat_i[15:0] & s_q.armed;
    end
    // Clear register takes ones, still only for flags read as set
    if (wr_clear) begin
      clr = lane_mask & wb_dat_i[15:0] & s_q.armed;
    end
    if (access && wb_we_i && (wb_adr_i == `TS_OFS_ENABLE)) begin
      s_d.enable = ((s_q.enable & ~lane_mask) | (wb_dat_i[15:0] & lane_mask)) & `TS_FLAG_MASK;
    end
    // Set wins over a clear in the same cycle
    s_d.flags = ((s_q.flags & ~clr) | set_all) & `TS_FLAG_MASK;
    s_d.armed = s_d.armed & ~clr & `TS_FLAG_MASK;
    s_d.irq = |(s_d.flags & s_d.enable);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.flags <= `TS_FLAGS_RESET;
      s_q.armed <= `TS_FLAGS_RESET;
      s_q.enable <= `TS_ENABLE_RESET;
      s_q.ack <= 1'b0;
      s_q.dat <= '0;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign irq = s_q.irq;

  property p_reserved_reads_zero;
    @(posedge clk) disable iff (sys_rst)
      (access && !wb_we_i && wb_adr_i == `TS_OFS_STATUS) |=>
        (wb_ack_o && wb_dat_o[15:0] == ($past(s_q.flags) & `TS_FLAG_MASK) && !wb_dat_o[15]);
  endproperty
  a_reserved_reads_zero: assert property (p_reserved_reads_zero) else $error("reserved bit read as one");

  property p_one_write_keeps;
    @(posedge clk) disable iff (sys_rst)
      (wr_status && wb_dat_i[15:0] == 16'hffff) |=> ((s_q.flags & $past(s_q.flags)) == $past(s_q.flags));
  endproperty
  a_one_write_keeps: assert property (p_one_write_keeps) else $error("writing one cleared a flag");

  property p_clear_needs_read;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |=> ((~s_q.flags & $past(s_q.flags) & ~$past(s_q.armed)) == 16'h0000);
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without prior read");

  property p_wrap_five;
    @(posedge clk) disable iff (sys_rst)
      ($past(chan_count[2]) == 16'hffff && chan_count[2] == 16'h0000 && g_chan[2].u_det.s_q.primed)
      |=> s_q.flags[`TS_BIT_OVF_FIVE];
  endproperty
  a_wrap_five: assert property (p_wrap_five) else $error("channel five overflow flag not set");

  property p_capture_d;
    @(posedge clk) disable iff (sys_rst)
      (chan_capture_strobe[2][3] && chan_capture_mode[2][3]) |=> s_q.flags[`TS_BIT_FLAG_D_FIVE] ##1 irq == |(s_q.flags & s_q.enable);
  endproperty
  a_capture_d: assert property (p_capture_d) else $error("capture did not set D flag");

  property p_pwm_match_d;
    @(posedge clk) disable iff (sys_rst)
      (chan_pwm_mode[2] && !chan_capture_mode[2][3] && g_chan[2].u_det.changed &&
       chan_count[2] == chan_general[2][3]) |=> s_q.flags[`TS_BIT_FLAG_D_FIVE];
  endproperty
  a_pwm_match_d: assert property (p_pwm_match_d) else $error("PWM match did not set D flag");

  property p_no_c_in_pwm;
    @(posedge clk) disable iff (sys_rst)
      $rose(s_q.flags[`TS_BIT_FLAG_C_FIVE]) |-> !$past(chan_pwm_mode[2]);
  endproperty
  a_no_c_in_pwm: assert property (p_no_c_in_pwm) else $error("C flag set in PWM mode");

  property p_no_b_in_pwm;
    @(posedge clk) disable iff (sys_rst)
      $rose(s_q.flags[`TS_BIT_FLAG_B_FIVE]) |-> !$past(chan_pwm_mode[2]);
  endproperty
  a_no_b_in_pwm: assert property (p_no_b_in_pwm) else $error("B flag set in PWM mode");

  property p_no_a_in_pwm;
    @(posedge clk) disable iff (sys_rst)
      $rose(s_q.flags[`TS_BIT_FLAG_A_FIVE]) |-> !$past(chan_pwm_mode[2]);
  endproperty
  a_no_a_in_pwm: assert property (p_no_a_in_pwm) else $error("A flag set in PWM mode");

  property p_set_beats_clear;
    @(posedge clk) disable iff (sys_rst)
      (wr_status || wr_clear) |=> ((s_q.flags & $past(set_all)) == $past(set_all));
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a coincident set");

  property p_irq_follows;
    @(posedge clk) disable iff (sys_rst)
      1'b1 |-> (irq == |(s_q.flags & s_q.enable));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow enabled flags");

endmodule

`default_nettype wire

//--- tb/test_timer_status_regs.sv
/*
  Self-checking bench for the status flag block of timer channels 3 to 5.
  Assumes the constants header, package, interface and design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "timer_status_defines.svh"

module test_timer_status_regs;
  import timer_status_pkg::*;
  localparam wb_addr_t st_ofs = `TS_OFS_STATUS;
  localparam wb_addr_t en_ofs = `TS_OFS_ENABLE;
  localparam wb_addr_t clr_ofs = `TS_OFS_CLEAR;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  wb_addr_t wb_adr_i = 4'h0;
  wb_sel_t wb_sel_i = 4'h3;
  wb_data_t wb_dat_i = 32'h0;
  logic wb_ack_o;
  wb_data_t wb_dat_o;
  chan_count_t chan_count = '0;
  chan_general_t chan_general = '0;
  chan_reg_bits_t chan_capture_strobe = '0;
  chan_reg_bits_t chan_capture_mode = '1;
  chan_bit_t chan_pwm_mode = '0;
  logic irq;
  int n_fail = 0;
  int checks_done = 0;
  word16_t rd;

  always #10 clk = ~clk;

  timer_status_regs timer_status_regs_inst (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .chan_count, .chan_general, .chan_capture_strobe,
    .chan_capture_mode, .chan_pwm_mode, .irq);

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input word16_t seen, input word16_t exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Ack and read data are taken at the rising edge; the request is released at that same edge
  task automatic bus(input logic we, input wb_addr_t adr, input word16_t wd, output word16_t rdat);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, wd};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      close_out();
    end else begin
      rdat = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask

  task automatic wr(input wb_addr_t adr, input word16_t wd);
    bus(1'b1, adr, wd, rd);
  endtask

  task automatic rdchk(input wb_addr_t adr, input word16_t exp);
    bus(1'b0, adr, 16'h0000, rd);
    check(rd, exp);
  endtask

  task automatic irqchk(input logic exp);
    @(negedge clk);
    check({15'h0000, irq}, {15'h0000, exp});
  endtask

  task automatic step(input word16_t v);
    @(posedge clk);
    chan_count <= {v, v, v};
  endtask

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(st_ofs, 16'h0000);
    rdchk(en_ofs, 16'h0000);
    rdchk(4'hc, 16'h0000);
    $display("test reset done");
    // Overflow on all channels, seen first only through irq
    wr(en_ofs, 16'h7fff);
    step(16'hffff);
    step(16'h0000);
    wr(st_ofs, 16'h0000);
    irqchk(1'b1);
    rdchk(st_ofs, 16'h4210);
    wr(st_ofs, 16'hffff);
    rdchk(st_ofs, 16'h4210);
    wr(st_ofs, 16'h0000);
    rdchk(st_ofs, 16'h0000);
    irqchk(1'b0);
    $display("test overflow done");
    // Capture into every register with the interrupt masked
    wr(en_ofs, 16'h0000);
    @(posedge clk);
    chan_capture_strobe <= '1;
    @(posedge clk);
    chan_capture_strobe <= '0;
    irqchk(1'b0);
    rdchk(st_ofs, 16'h3def);
    wr(clr_ofs, 16'h3def);
    rdchk(st_ofs, 16'h0000);
    $display("test capture done");
    // Counter walks onto each compare value
    @(posedge clk);
    chan_capture_mode <= '0;
    for (int c = 0; c < 3; c++) begin
      for (int r = 0; r < 4; r++) begin
        chan_general[c][r] <= 16'h0100 + 16'(r);
      end
    end
    for (int v = 0; v < 4; v++) step(16'h0100 + 16'(v));
    rdchk(st_ofs, 16'h3def);
    wr(st_ofs, 16'h0000);
    rdchk(st_ofs, 16'h0000);
    $display("test compare done");
    // PWM mode keeps only the synchronising match on D
    @(posedge clk);
    chan_pwm_mode <= '1;
    step(16'h0000);
    for (int v = 0; v < 4; v++) step(16'h0100 + 16'(v));
    rdchk(st_ofs, 16'h2108);
    $display("test pwm done");
    // D capture lands on the same edge as the clearing write
    @(posedge clk);
    chan_capture_mode <= '1;
    fork
      wr(st_ofs, 16'h0000);
      begin
        @(posedge clk);
        chan_capture_strobe <= 12'h888;
        @(posedge clk);
        chan_capture_strobe <= '0;
      end
    join
    rdchk(st_ofs, 16'h2108);
    $display("test set against clear done");
    // Only the low byte lane of enable is written
    wb_sel_i <= 4'h1;
    wr(en_ofs, 16'hffff);
    wb_sel_i <= 4'h3;
    rdchk(en_ofs, 16'h00ff);
    irqchk(1'b1);
    $display("test byte lanes done");
    // Mid-run reset clears flags, enable and interrupt
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    irqchk(1'b0);
    rdchk(st_ofs, 16'h0000);
    rdchk(en_ofs, 16'h0000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule

`default_nettype wire
